// ===== rtl/cmp_irq_top.sv
// Register file, pin multiplexers and interrupt logic of the dual comparator.
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
// ==========================================================
// Overview of operation
// R1: Status bits 0 and 1 read-only results.
// R2: Pin enable routes result to pin.
// R3: Direction bits still gate pin drive.
// R4: Invert bit complements reported result.
// R5: Edge field at control bits 4:3.
// R6: Single-edge modes set sticky flag.
// R7: Any-change mode flags every transition.
// R8: Edges seen after polarity adjustment.
// R9: Flags at bits 6:5, software writable.
// R10: Request needs source, peripheral, global enables.
// R11: Flags set regardless of enables.
// R12: Enabled interrupt wakes device from sleep.
// R13: Wake leaves control registers untouched.
// R14: Reset returns control registers, comparators off.
// R15: Software turns comparators off before sleep.
// R16: Software tracks status for any-change.
// R17: Package limits available channel configurations.
// R18: Edge codes: off, rising, falling.
// R19: Selecting any-change sets the flag.
// R20: Raw results pass two-flop synchroniser.
// R21: Disabled comparator reads low, no events.
// ==========================================================
module cmp_irq_top
    import cmp_pkg::*;
#(
    parameter bit LARGE_PACKAGE = 1'b1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] raw_result,
    input wire logic [1:0] port_latch,
    input wire logic [1:0] port_six_direction,
    input wire logic sleep_mode,
    output logic first_result_pin_out,
    output logic first_result_pin_oe,
    output logic second_result_pin_out,
    output logic second_result_pin_oe,
    output logic [1:0] comparator_on,
    output logic [1:0] reference_select,
    output logic [1:0] first_channel_select,
    output logic [1:0] second_channel_select,
    output logic comparator_irq_request,
    output logic wake_request
);
    import cmp_pkg::*;

    // ==========================================================
    // Declarations
    // ==========================================================
    logic [7:0] ctrl_reg [NUM_CMP]; // Per-comparator control.
    logic [7:0] flags_reg; // peripheral_flags_two.
    logic [7:0] flags_next; // Next flag byte.
    logic [7:0] enables_reg; // peripheral_enables_two.
    logic [7:0] prio_reg; // peripheral_priorities_two, storage only.
    logic [7:0] intctl_reg; // interrupt_control.
    logic [31:0] prdata_reg; // Read data captured in the setup cycle.
    logic [7:0] read_mux; // Byte selected by the address.
    logic [7:0] status_byte; // comparator_result_status view.
    logic mapped; // Address hits a register.
    logic wr_en; // Write completes this edge.
    logic rd_setup; // Read data load cycle.
    logic rd_hold_reg; // Read data already loaded for this transfer.
    logic [1:0] wr_ctrl; // Write to each control register.
    logic [1:0] result; // Adjusted results.
    logic [1:0] event_hit; // Qualifying edge per comparator.
    logic [1:0] any_select; // Any-change mode newly selected.
    logic [1:0] hw_set; // Hardware flag sets.
    logic [1:0] cfg_ok; // Selected channel exists in this package.
    logic [1:0] run; // Comparator enabled and configured.
    logic [1:0] irq_flag; // comparator_irq_flag view.
    logic [1:0] irq_enable; // comparator_irq_enable view.
    logic [1:0] pin_enable; // result_pin_enable view.
    logic [1:0] pin_mux; // Pin data after multiplexer.

    // ==========================================================
    // Bus decode
    // ==========================================================
    // Zero wait states while ce is high; a read whose setup edge saw ce low waits one enabled cycle.
    assign pready = ce && !(psel && penable && !pwrite && !rd_hold_reg);
    assign wr_en = psel && penable && pwrite && ce && pstrb[0];
    assign rd_setup = psel && !pwrite && ce && !rd_hold_reg;
    assign pslverr = psel && penable && !mapped;
    assign wr_ctrl[0] = wr_en && (paddr == OFS_CTRL1);
    assign wr_ctrl[1] = wr_en && (paddr == OFS_CTRL2);

    // Address decode and read selection; unmapped reads return zero.
    always_comb begin
        status_byte = 8'h00;
        status_byte[STAT_LO_BIT +: NUM_CMP] = result; // R1
        mapped = 1'b1;
        case (paddr)
            OFS_CTRL1: read_mux = ctrl_reg[0];
            OFS_CTRL2: read_mux = ctrl_reg[1];
            OFS_STATUS: read_mux = status_byte; // R1
            OFS_FLAGS: read_mux = flags_reg;
            OFS_ENABLES: read_mux = enables_reg;
            OFS_PRIO: read_mux = prio_reg;
            OFS_INTCTL: read_mux = intctl_reg;
            default: begin
                read_mux = 8'h00;
                mapped = 1'b0;
            end
        endcase
    end

    // Read data comes from a flop so prdata is steady during the access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_reg <= {24'h00_0000, read_mux};
        end
    end
    assign prdata = prdata_reg;

    // A read whose setup edge fell while ce was low has loaded nothing yet;
    // holding pready low for one enabled cycle beats handing back a stale
    // word. The mark clears at the completing edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_hold_reg <= 1'b0;
        end else if (ce) begin
            rd_hold_reg <= rd_setup || (rd_hold_reg && psel && !penable);
        end
    end

    // ==========================================================
    // Per-comparator logic
    // ==========================================================
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
            // Control register; a sleep wake never touches it, only reset and bus writes do.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ctrl_reg[gi] <= CTRL_RESET; // R14
                end else if (wr_ctrl[gi]) begin
                    ctrl_reg[gi] <= pwdata[7:0]; // R13
                end
            end

            // Unbonded channels keep the comparator idle rather than
            // letting it compare a floating input.
            always_comb begin
                case (ctrl_reg[gi][CTRL_CH_HI:CTRL_CH_LO])
                    CHAN_B: cfg_ok[gi] = 1'b1; // R17
                    CHAN_VIRV: cfg_ok[gi] = 1'b1; // R17
                    CHAN_C: cfg_ok[gi] = LARGE_PACKAGE; // R17
                    CHAN_D: cfg_ok[gi] = LARGE_PACKAGE && (gi == 1); // R17
                    default: cfg_ok[gi] = 1'b0;
                endcase
            end

            assign run[gi] = ctrl_reg[gi][CTRL_ON_BIT] && cfg_ok[gi];
            assign comparator_on[gi] = run[gi];
            assign reference_select[gi] = ctrl_reg[gi][CTRL_REF_BIT];
            assign pin_enable[gi] = ctrl_reg[gi][CTRL_PIN_BIT];
            assign irq_flag[gi] = flags_reg[IRQ_LO_BIT + gi];
            assign irq_enable[gi] = enables_reg[IRQ_LO_BIT + gi];

            // Any-change selected by a write sets the flag once.
            assign any_select[gi] = wr_ctrl[gi] && // R19
                (pwdata[CTRL_EDGE_HI:CTRL_EDGE_LO] == EDGE_ANY) &&
                (ctrl_reg[gi][CTRL_EDGE_HI:CTRL_EDGE_LO] != EDGE_ANY);
            assign hw_set[gi] = event_hit[gi] || any_select[gi]; // R11

            cmp_result_path u_path (
                .pclk(pclk),
                .presetn(presetn),
                .ce(ce),
                .raw_result(raw_result[gi]),
                .comparator_on(run[gi]),
                .result_invert(ctrl_reg[gi][CTRL_INV_BIT]), // R4
                .irq_edge_select(edge_sel_t'(ctrl_reg[gi][CTRL_EDGE_HI:CTRL_EDGE_LO])), // R5
                .result(result[gi]),
                .event_hit(event_hit[gi])
            );

            // Pin multiplexer: port latch or comparator result.
            assign pin_mux[gi] = pin_enable[gi] ? result[gi] : port_latch[gi]; // R2
        end
    endgenerate

    assign first_channel_select = ctrl_reg[0][CTRL_CH_HI:CTRL_CH_LO];
    assign second_channel_select = ctrl_reg[1][CTRL_CH_HI:CTRL_CH_LO];

    // ==========================================================
    // Pins
    // ==========================================================
    // A direction bit of one means input, so the pin is released.
    assign first_result_pin_out = pin_mux[0];
    assign second_result_pin_out = pin_mux[1];
    assign first_result_pin_oe = !port_six_direction[0]; // R3
    assign second_result_pin_oe = !port_six_direction[1]; // R3

    // ==========================================================
    // Interrupt registers
    // ==========================================================
    // Hardware sets win over a software clear in the same cycle, so
    // no event is lost; software may also set a flag to simulate one.
    always_comb begin
        flags_next = flags_reg;
        if (wr_en && (paddr == OFS_FLAGS)) begin
            flags_next = pwdata[7:0]; // R9
        end
        for (int i = 0; i < NUM_CMP; i++) begin
            if (hw_set[i]) begin
                flags_next[IRQ_LO_BIT + i] = 1'b1; // R6 R7 R11
            end
        end
    end

    // The flag register holds every source of the peripheral group.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= FLAGS_RESET;
        end else if (ce) begin
            flags_reg <= flags_next; // R6
        end
    end

    // Enable, priority and global control bytes are plain storage.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enables_reg <= ENABLES_RESET;
            prio_reg <= PRIO_RESET;
            intctl_reg <= INTCTL_RESET;
        end else if (wr_en) begin
            if (paddr == OFS_ENABLES) begin
                enables_reg <= pwdata[7:0];
            end
            if (paddr == OFS_PRIO) begin
                prio_reg <= pwdata[7:0];
            end
            if (paddr == OFS_INTCTL) begin
                intctl_reg <= pwdata[7:0];
            end
        end
    end

    // Request needs all three gates; wake ignores the peripheral and global gates so
    // a masked core can still leave sleep and poll.
    assign comparator_irq_request = |(irq_flag & irq_enable) && // R10
        intctl_reg[PERIPHERAL_IRQ_ENABLE_BIT] && intctl_reg[GIE_BIT];
    assign wake_request = sleep_mode && |(irq_flag & irq_enable); // R12

    // ==========================================================
    // Checks
    // ==========================================================
    sequence s_flags_untouched;
        !(wr_en && paddr == OFS_FLAGS);
    endsequence

    sequence s_read_status;
        rd_setup && paddr == OFS_STATUS;
    endsequence

    property p_status_view;
        @(posedge pclk) disable iff (!presetn)
        s_read_status |=> (prdata[1:0] == $past(result) && prdata[7:2] == 6'h00);
    endproperty

    a_status_read: assert property (p_status_view) // R1
        else $error("status read does not show results");

    a_status_ro: assert property (@(posedge pclk) disable iff (!presetn) // R1
        (wr_en && paddr == OFS_STATUS) |-> !pslverr ##0 (wr_ctrl == 2'b00))
        else $error("status write reached a register");

    a_pin_mux_sel: assert property (@(posedge pclk) disable iff (!presetn) // R2
        pin_enable[0] |-> first_result_pin_out == result[0])
        else $error("pin not driven by result");

    a_pin_dir_gate: assert property (@(posedge pclk) disable iff (!presetn) // R3
        port_six_direction[1] |-> !second_result_pin_oe)
        else $error("pin driven while set to input");

    a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn) // R6
        (irq_flag[0] && ce) ##0 s_flags_untouched |=> irq_flag[0])
        else $error("flag cleared without software");

    a_event_sets: assert property (@(posedge pclk) disable iff (!presetn) // R11
        event_hit[1] |=> irq_flag[1])
        else $error("event did not set flag");

    a_edge_off_quiet: assert property (@(posedge pclk) disable iff (!presetn) // R18
        (ctrl_reg[0][CTRL_EDGE_HI:CTRL_EDGE_LO] == EDGE_OFF) |-> !event_hit[0])
        else $error("event with edge select off");

    a_sw_set_flag: assert property (@(posedge pclk) disable iff (!presetn) // R9
        (wr_en && paddr == OFS_FLAGS && pwdata[IRQ_LO_BIT]) |=> irq_flag[0])
        else $error("software set lost");

    a_any_select: assert property (@(posedge pclk) disable iff (!presetn) // R19
        (any_select[1] && ce) |=> irq_flag[1] ##1 1'b1)
        else $error("any-change select did not set flag");

    a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn) // R10
        !intctl_reg[GIE_BIT] |-> !comparator_irq_request)
        else $error("request with global gate closed");

    a_wake_sleep: assert property (@(posedge pclk) disable iff (!presetn) // R12
        (sleep_mode && irq_flag[0] && irq_enable[0]) |-> wake_request)
        else $error("enabled flag did not wake");

    // Completion, reset, hold, unbonded-channel, set-wins and pin checks.
    a_read_complete: assert property (@(posedge pclk) disable iff (!presetn) // R1
        (psel && penable && pready && !pwrite && paddr == OFS_STATUS) |-> prdata[1:0] == $past(result))
        else $error("stale read data");

    a_reset_ctrl: assert property (@(posedge pclk) $rose(presetn) |-> // R14
        ctrl_reg[0] == CTRL_RESET && ctrl_reg[1] == CTRL_RESET)
        else $error("control not reset");

    a_ctrl_hold: assert property (@(posedge pclk) disable iff (!presetn) // R13
        !wr_ctrl[1] |=> $stable(ctrl_reg[1]))
        else $error("control changed unwritten");

    a_unbonded_off: assert property (@(posedge pclk) disable iff (!presetn) // R17
        (ctrl_reg[0][CTRL_CH_HI:CTRL_CH_LO] == CHAN_D) |-> !comparator_on[0])
        else $error("unbonded channel on");

    a_set_wins: assert property (@(posedge pclk) disable iff (!presetn) // R11
        (hw_set[0] && ce) |=> irq_flag[0])
        else $error("set lost to clear");

    a_first_pin_oe: assert property (@(posedge pclk) disable iff (!presetn) // R3
        !port_six_direction[0] |-> first_result_pin_oe)
        else $error("pin not driven");

endmodule

// ===== rtl/cmp_pkg.sv
// Package of register offsets, field positions and reset values for the comparator back end.
package cmp_pkg;

    // ==========================================================
    // Sizes
    // ==========================================================
    localparam int unsigned NUM_CMP = 2; // Two comparators.
    localparam int unsigned DATA_W = 8; // Width of every register.

    // ==========================================================
    // Register byte offsets on the APB
    // ==========================================================
    localparam logic [7:0] OFS_CTRL1 = 8'h00; // First comparator_control.
    localparam logic [7:0] OFS_CTRL2 = 8'h04; // Second comparator_control.
    localparam logic [7:0] OFS_STATUS = 8'h08; // comparator_result_status.
    localparam logic [7:0] OFS_FLAGS = 8'h0c; // peripheral_flags_two.
    localparam logic [7:0] OFS_ENABLES = 8'h10; // peripheral_enables_two.
    localparam logic [7:0] OFS_PRIO = 8'h14; // peripheral_priorities_two.
    localparam logic [7:0] OFS_INTCTL = 8'h18; // interrupt_control.

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int unsigned CTRL_ON_BIT = 7; // comparator_on.
    localparam int unsigned CTRL_PIN_BIT = 6; // result_pin_enable.
    localparam int unsigned CTRL_INV_BIT = 5; // result_invert.
    localparam int unsigned CTRL_EDGE_HI = 4; // irq_edge_select, upper bit.
    localparam int unsigned CTRL_EDGE_LO = 3; // irq_edge_select, lower bit.
    localparam int unsigned CTRL_REF_BIT = 2; // Non-inverting reference select.
    localparam int unsigned CTRL_CH_HI = 1; // Inverting channel select, upper bit.
    localparam int unsigned CTRL_CH_LO = 0; // Inverting channel select, lower bit.
    localparam int unsigned STAT_LO_BIT = 0; // First result in the status register.
    localparam int unsigned IRQ_LO_BIT = 5; // First comparator flag and enable bit.
    localparam int unsigned PERIPHERAL_IRQ_ENABLE_BIT = 6; // peripheral_irq_enable.
    localparam int unsigned GIE_BIT = 7; // global_irq_enable.

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] CTRL_RESET = 8'h1f; // Off, any-change, VIRV channel.
    localparam logic [7:0] FLAGS_RESET = 8'h00; // No flag pending.
    localparam logic [7:0] ENABLES_RESET = 8'h00; // All sources masked.
    localparam logic [7:0] PRIO_RESET = 8'h00; // Plain storage.
    localparam logic [7:0] INTCTL_RESET = 8'h00; // Global gates closed.

    // ==========================================================
    // Encodings
    // ==========================================================
    typedef enum logic [1:0] {
        EDGE_OFF = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_ANY = 2'b11
    } edge_sel_t;

    localparam logic [1:0] CHAN_B = 2'b00; // Always bonded out.
    localparam logic [1:0] CHAN_C = 2'b01; // Fixed channel port, large package.
    localparam logic [1:0] CHAN_D = 2'b10; // Fixed channel port, second comparator only.
    localparam logic [1:0] CHAN_VIRV = 2'b11; // Internal fixed reference.

endpackage

// ===== rtl/cmp_result_path.sv
// One comparator's synchroniser, polarity stage and edge detector.
`timescale 1ns/1ps
module cmp_result_path
    import cmp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic raw_result,
    input wire logic comparator_on,
    input wire logic result_invert,
    input wire cmp_pkg::edge_sel_t irq_edge_select,
    output logic result,
    output logic event_hit
);
    import cmp_pkg::*;

    logic sync1_reg; // First synchroniser stage, read only by the second.
    logic sync2_reg; // Second synchroniser stage.
    logic result_reg; // Polarity-adjusted result.
    logic result_next; // Next adjusted result.
    logic on_d_reg; // Enable seen in the previous cycle.
    logic rise; // Adjusted result goes low to high.
    logic fall; // Adjusted result goes high to low.

    // ==========================================================
    // Synchroniser
    // ==========================================================
    // The analog result is asynchronous, so it settles in two flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else if (ce) begin
            sync1_reg <= raw_result; // R20
            sync2_reg <= sync1_reg; // R20
        end
    end

    // ==========================================================
    // Polarity and edges
    // ==========================================================
    // A disabled comparator reads low; edges count only across two enabled cycles.
    always_comb begin
        result_next = comparator_on ? (sync2_reg ^ result_invert) : 1'b0; // R4 R21
        rise = !result_reg && result_next; // R8
        fall = result_reg && !result_next; // R8
        event_hit = 1'b0;
        if (ce && comparator_on && on_d_reg) begin
            case (irq_edge_select)
                EDGE_RISE: event_hit = rise; // R6 R18
                EDGE_FALL: event_hit = fall; // R6 R18
                EDGE_ANY: event_hit = rise || fall; // R7
                default: event_hit = 1'b0; // R18
            endcase
        end
    end

    // The adjusted result and the enable history advance together.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= 1'b0;
            on_d_reg <= 1'b0;
        end else if (ce) begin
            result_reg <= result_next;
            on_d_reg <= comparator_on;
        end
    end

    assign result = result_reg;

    // ==========================================================
    // Checks
    // ==========================================================
    a_off_reads_low: assert property (@(posedge pclk) disable iff (!presetn) // R21
        (ce && !comparator_on) |=> !result)
        else $error("disabled comparator result not low");
    a_off_no_event: assert property (@(posedge pclk) disable iff (!presetn) // R21
        !comparator_on |-> !event_hit)
        else $error("event from disabled comparator");
    a_rise_sets_high: assert property (@(posedge pclk) disable iff (!presetn) // R6
        (event_hit && irq_edge_select == EDGE_RISE) |=> result)
        else $error("rising event without high result");

endmodule

// ===== sim/cmp_analog_model.sv
// Behavioural model of the two analog comparator cores feeding the back end.
`timescale 1ns/1ps
module cmp_analog_model (
    input wire logic pclk,
    input wire logic [1:0] vin_diff,
    output logic [1:0] raw_result
);
    // ==========================================================
    // Response
    // ==========================================================
    // A core reports high while its non-inverting input is above the inverting one.
    // The late, off-edge change keeps the result asynchronous to the bus clock.
    initial raw_result = 2'b00;
    always @(posedge pclk) begin
        raw_result <= #3 vin_diff;
    end
endmodule

// ===== sim/test_cmp_irq_top.sv
// Self-checking bench of the comparator back end against a behavioural model.
`timescale 1ns/1ps
module test_cmp_irq_top;
    import cmp_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_mode = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic [1:0] vin_diff = 2'b00, port_latch = 2'b00, dir = 2'b11, raw_result, cmp_on, ref_sel, ch1, ch2;
    logic pready, pslverr, p1_out, p1_oe, p2_out, p2_oe, irq, wake, err;
    int fail_count = 0, cmp_count = 0;
    // Model state: registers, adjusted results and the enable seen at the last step.
    logic [7:0] ctrl[2], flags, en, ic;
    logic [1:0] res, was_on, onv;
    always #5 pclk = ~pclk;
    cmp_analog_model core (.pclk(pclk), .vin_diff(vin_diff), .raw_result(raw_result));
    cmp_irq_top #(.LARGE_PACKAGE(1'b1)) dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .raw_result(raw_result), .port_latch(port_latch),
        .port_six_direction(dir), .sleep_mode(sleep_mode), .first_result_pin_out(p1_out),
        .first_result_pin_oe(p1_oe), .second_result_pin_out(p2_out), .second_result_pin_oe(p2_oe),
        .comparator_on(cmp_on), .reference_select(ref_sel), .first_channel_select(ch1),
        .second_channel_select(ch2), .comparator_irq_request(irq), .wake_request(wake));
    // ==========================================================
    // Report
    // ==========================================================
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ==========================================================
    // APB master: entered just after a rising edge, returns one edge after pready is sampled.
    // ==========================================================
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 50) begin
                fail_count++;
                give_verdict();
            end
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // The first comparator has no channel 10.
    function automatic logic avail(input int i, input logic [1:0] c);
        return !(i == 0 && c == 2'b10);
    endfunction
    // Lets one change settle, steps the model, then compares every visible result.
    task automatic settle();
        logic on;
        logic [1:0] m;
        logic pend;
        repeat (6) @(posedge pclk);
        for (int i = 0; i < 2; i++) begin
            on = ctrl[i][7] && avail(i, ctrl[i][1:0]);
            m = ctrl[i][4:3];
            if (on && was_on[i] && (ctrl[i][5] ^ vin_diff[i]) != res[i] && (m == 2'b11 || m == {res[i], !res[i]}))
                flags[5 + i] = 1'b1;
            res[i] = on & (ctrl[i][5] ^ vin_diff[i]);
            was_on[i] = on;
            onv[i] = on;
        end
        apb(1'b0, OFS_STATUS, 8'h00, 4'hf);
        check(rd, {30'h0, res});
        apb(1'b0, OFS_FLAGS, 8'h00, 4'hf);
        check(rd, {24'h0, flags});
        for (int i = 0; i < 2; i++) begin
            apb(1'b0, i ? OFS_CTRL2 : OFS_CTRL1, 8'h00, 4'hf);
            check(rd, {24'h0, ctrl[i]});
        end
        pend = (flags & en & 8'h60) != 8'h00;
        check({irq, wake, p2_out, p1_out, p2_oe, p1_oe, cmp_on}, {pend & ic[7] & ic[6], pend & sleep_mode,
            ctrl[1][6] ? res[1] : port_latch[1], ctrl[0][6] ? res[0] : port_latch[0], ~dir, onv});
        check({ref_sel, ch2, ch1}, {ctrl[1][2], ctrl[0][2], ctrl[1][1:0], ctrl[0][1:0]});
    endtask
    // Register write with the model updated alongside.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 4'h1);
        if (a == OFS_CTRL1 || a == OFS_CTRL2) begin
            if (d[4:3] == 2'b11 && ctrl[a[2]][4:3] != 2'b11) flags[5 + a[2]] = 1'b1;
            ctrl[a[2]] = d;
        end
        if (a == OFS_FLAGS) flags = d;
        if (a == OFS_ENABLES) en = d;
        if (a == OFS_INTCTL) ic = d;
        settle();
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        ctrl = '{CTRL_RESET, CTRL_RESET};
        {flags, en, ic, res, was_on} = '0;
        @(posedge pclk);
    endtask
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        logic [31:0] v;
        void'($urandom(22));
        do_reset();
        settle();
        apb(1'b0, 8'h1c, 8'h00, 4'hf);
        check({err, rd[30:0]}, 32'h80000000);
        wr(OFS_STATUS, 8'hff);
        wr(OFS_ENABLES, 8'h60);
        apb(1'b1, OFS_ENABLES, 8'h00, 4'h0);
        settle();
        // Every edge code with random polarity, routing, channels, gates and inputs.
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 6; k++) begin
                v = $urandom;
                port_latch <= v[1:0];
                dir <= v[3:2];
                sleep_mode <= v[4];
                wr(OFS_INTCTL, {v[6:5], 6'h0});
                wr(OFS_CTRL1, {1'b1, v[7], v[8], m[1:0], v[17], v[14:13]});
                wr(OFS_CTRL2, {1'b1, v[9], v[10], m[1:0], v[18], v[16:15]});
                vin_diff <= v[12:11];
                settle();
                if (k == 2) wr(OFS_FLAGS, {1'b0, v[20:19], 5'h00});
            end
        end
        // Sleep entered, then both cores off: pending flags still wake the device.
        sleep_mode <= 1'b1;
        wr(OFS_CTRL1, 8'h00);
        wr(OFS_CTRL2, 8'h00);
        do_reset();
        settle();
        give_verdict();
    end
endmodule
